/* src/plg_ctrl.sv */
`include "plg_map.svh"

// Behaviour
// - With the crystal select bit at 0 the reference pin pair is a differential clock input.
// - With the crystal select bit at 1 the positive pin feeds the amplifier and, while the power-down bit is 0, the negative pin is its driven output.
// - Writing 1 to the sync bit arms the sync circuit and the later fall to 0 fires a divider sync.
// - Setting the calibration bit to 1 runs the oscillator calibration sequence.
// - The power-down bit at 1 holds the predivider, aborts calibration and releases the negative pin, but sync still fires; at 0 the loop runs.
// - Charge-pump current is automatic while the manual bit is 0 and set by the code when it is 1.
// - The current code has no effect while the manual bit is 0.
// - The current code maps linearly from 125 uA at 000 to 1000 uA at 111 in 125 uA steps.
// - A predivider field of 0 divides the reference by 16.
// - Predivider fields 1 to 15 divide the reference by that value.
// - Written values take effect only on an update, a write of 1 to bit 0 of the update register.
module plg_ctrl #(
   parameter int CAL_CYCLES = `PLG_CAL_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Reference pins
   input wire logic second_reference_pos,
   input wire logic second_reference_neg_in,
   output logic second_reference_neg_out,
   output logic second_reference_neg_oe_n,
   // Loop controls
   output plg_pkg::plg_ref_mode_t ref_mode,
   output logic second_loop_power_down,
   output logic sync_armed,
   output logic sync_pulse,
   output logic cal_busy,
   output logic cp_manual,
   output logic [10:0] cp_current_ua,
   output logic [4:0] reference_predivider_ratio,
   output logic ref_div_tick
);

   function automatic logic [7:0] reg_mask(input logic [11:0] a);
      unique case (a)
         `PLG_ADDR_GENERAL: reg_mask = `PLG_MASK_GENERAL;
         `PLG_ADDR_CPUMP: reg_mask = `PLG_MASK_CPUMP;
         `PLG_ADDR_REFDIV: reg_mask = `PLG_MASK_REFDIV;
         default: reg_mask = 8'h00;
      endcase
   endfunction : reg_mask

   // Written (shadow) and applied copies
   logic [7:0] shd_gen, shd_cp, shd_ref;
   logic [7:0] act_gen, act_cp, act_ref;
   logic [7:0] next_shd_gen, next_shd_cp, next_shd_ref;
   logic [7:0] next_act_gen, next_act_cp, next_act_ref;
   logic [7:0] next_rd_data;
   logic next_rd_valid;
   logic io_update;

   assign io_update = wr_en && addr == `PLG_ADDR_UPDATE && wdata[`PLG_BIT_UPDATE];

   always_comb begin
      next_shd_gen = shd_gen;
      next_shd_cp = shd_cp;
      next_shd_ref = shd_ref;
      if (wr_en) begin
         if (addr == `PLG_ADDR_GENERAL) begin
            next_shd_gen = wdata & reg_mask(addr);
         end
         if (addr == `PLG_ADDR_CPUMP) begin
            next_shd_cp = wdata & reg_mask(addr);
         end
         if (addr == `PLG_ADDR_REFDIV) begin
            next_shd_ref = wdata & reg_mask(addr);
         end
      end
      // Update copies what was written before this cycle
      next_act_gen = io_update ? shd_gen : act_gen;
      next_act_cp = io_update ? shd_cp : act_cp;
      next_act_ref = io_update ? shd_ref : act_ref;
      next_rd_valid = rd_en;
      next_rd_data = 8'h00;
      if (rd_en) begin
         unique case (addr)
            `PLG_ADDR_GENERAL: next_rd_data = shd_gen;
            `PLG_ADDR_CPUMP: next_rd_data = shd_cp;
            `PLG_ADDR_REFDIV: next_rd_data = shd_ref;
            default: next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         shd_gen <= `PLG_RST_GENERAL;
         shd_cp <= `PLG_RST_CPUMP;
         shd_ref <= `PLG_RST_REFDIV;
         act_gen <= `PLG_RST_GENERAL;
         act_cp <= `PLG_RST_CPUMP;
         act_ref <= `PLG_RST_REFDIV;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         shd_gen <= next_shd_gen;
         shd_cp <= next_shd_cp;
         shd_ref <= next_shd_ref;
         act_gen <= next_act_gen;
         act_cp <= next_act_cp;
         act_ref <= next_act_ref;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end

   // Static controls from the applied copy
   assign ref_mode = plg_pkg::plg_ref_mode_t'(act_gen[`PLG_BIT_XTAL]);
   assign second_loop_power_down = act_gen[`PLG_BIT_PDOWN];
   assign sync_armed = act_gen[`PLG_BIT_SYNC];
   assign cp_manual = act_cp[`PLG_BIT_CP_MANUAL];
   // Auto mode reports zero so the code cannot leak through
   assign cp_current_ua = cp_manual ? 11'((act_cp[2:0] + 11'h001) * `PLG_CP_STEP_UA) : 11'h000;
   assign reference_predivider_ratio = (act_ref[3:0] == 4'h0) ? `PLG_REFDIV_ZERO_RATIO
                                       : {1'b0, act_ref[3:0]};

   // Sync fires on the applied falling edge, calibration on the applied rising edge
   plg_pkg::plg_cal_state_t cal_state, next_cal_state;
   logic [15:0] cal_count, next_cal_count;
   logic next_sync_pulse;

   always_comb begin
      next_sync_pulse = io_update && act_gen[`PLG_BIT_SYNC] && !shd_gen[`PLG_BIT_SYNC];
      next_cal_state = cal_state;
      next_cal_count = cal_count;
      unique case (cal_state)
         plg_pkg::PLG_CAL_IDLE: begin
            if (io_update && !act_gen[`PLG_BIT_CAL] && shd_gen[`PLG_BIT_CAL]) begin
               next_cal_state = plg_pkg::PLG_CAL_RUN;
               next_cal_count = 16'(CAL_CYCLES - 1);
            end
         end
         plg_pkg::PLG_CAL_RUN: begin
            // Power-down aborts a calibration in flight
            if (second_loop_power_down || cal_count == 16'h0000) begin
               next_cal_state = plg_pkg::PLG_CAL_IDLE;
               next_cal_count = 16'h0000;
            end else begin
               next_cal_count = cal_count - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cal_state <= plg_pkg::PLG_CAL_IDLE;
         cal_count <= 16'h0000;
         sync_pulse <= 1'b0;
      end else begin
         cal_state <= next_cal_state;
         cal_count <= next_cal_count;
         sync_pulse <= next_sync_pulse;
      end
   end

   assign cal_busy = cal_state == plg_pkg::PLG_CAL_RUN;

   // Reference pins, two flops before use; neg input only matters in differential mode
   logic [1:0] pos_sync, neg_sync;
   logic pos_prev, ref_level, ref_tick;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pos_sync <= 2'b00;
         neg_sync <= 2'b00;
         pos_prev <= 1'b0;
         second_reference_neg_out <= 1'b0;
      end else begin
         pos_sync <= {pos_sync[0], second_reference_pos};
         neg_sync <= {neg_sync[0], second_reference_neg_in};
         pos_prev <= ref_level;
         second_reference_neg_out <= !pos_sync[1];
      end
   end

   always_comb begin
      if (ref_mode == plg_pkg::PLG_REF_XTAL) begin
         ref_level = pos_sync[1];
      end else begin
         ref_level = pos_sync[1] && !neg_sync[1];
      end
   end

   assign ref_tick = ref_level && !pos_prev;
   // Negative pin is released as an input unless it carries the amplifier output
   assign second_reference_neg_oe_n = !(ref_mode == plg_pkg::PLG_REF_XTAL
                                        && !second_loop_power_down);

   plg_ref_prediv u_prediv (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ref_tick(ref_tick),
      .ratio(reference_predivider_ratio),
      .power_down(second_loop_power_down),
      .div_tick(ref_div_tick)
   );

   sequence s_cal_request;
      io_update && !act_gen[`PLG_BIT_CAL] && shd_gen[`PLG_BIT_CAL] && !cal_busy;
   endsequence

   // Run length is a parameter, so the count is followed step by step
   sequence s_cal_run;
      cal_busy && cal_count == 16'(CAL_CYCLES - 1);
   endsequence

   sequence s_cal_step;
      cal_busy && cal_count != 16'h0000 && !second_loop_power_down;
   endsequence

   chk_cal_start_run: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_cal_request |=> s_cal_run)
      else $error("calibration did not start");

   chk_cal_count_down: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_cal_step |=> cal_busy && cal_count == $past(cal_count) - 16'h0001)
      else $error("calibration count skipped");

   chk_cal_end_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      cal_busy && cal_count == 16'h0000 |=> !cal_busy)
      else $error("calibration did not end");

   chk_sync_fall_fire: assert property (@(posedge core_clk) disable iff (!rst_n)
      io_update && sync_armed && !shd_gen[`PLG_BIT_SYNC] |=> sync_pulse && !sync_armed)
      else $error("sync did not fire on falling bit");

   chk_sync_needs_arm: assert property (@(posedge core_clk) disable iff (!rst_n)
      sync_pulse |-> $past(sync_armed) && !sync_armed)
      else $error("sync fired without arming");

   chk_update_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      !io_update |=> $stable(act_gen) && $stable(act_cp) && $stable(act_ref))
      else $error("applied value changed without update");

   chk_update_apply: assert property (@(posedge core_clk) disable iff (!rst_n)
      io_update |=> act_gen == $past(shd_gen) && act_cp == $past(shd_cp)
                    && act_ref == $past(shd_ref))
      else $error("update did not apply written values");

   chk_xtal_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
      ref_mode == plg_pkg::PLG_REF_XTAL && !second_loop_power_down |-> !second_reference_neg_oe_n)
      else $error("crystal amplifier output not driven");

   chk_diff_input: assert property (@(posedge core_clk) disable iff (!rst_n)
      ref_mode == plg_pkg::PLG_REF_DIFF |-> second_reference_neg_oe_n)
      else $error("negative pin driven in differential mode");

   chk_cp_auto_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      !cp_manual |-> cp_current_ua == 11'h000)
      else $error("current code leaks in automatic mode");

   chk_cp_linear: assert property (@(posedge core_clk) disable iff (!rst_n)
      cp_manual && act_cp[2:0] == 3'h7 |-> cp_current_ua == 11'h3E8)
      else $error("top current code is not 1000 uA");

   chk_ratio_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      act_ref[3:0] == 4'h0 |-> reference_predivider_ratio == 5'h10)
      else $error("zero code does not divide by 16");

   chk_ratio_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
      act_ref[3:0] != 4'h0 |-> reference_predivider_ratio == {1'b0, act_ref[3:0]})
      else $error("predivider ratio differs from code");

   chk_pd_no_ticks: assert property (@(posedge core_clk) disable iff (!rst_n)
      second_loop_power_down ##1 second_loop_power_down |-> !ref_div_tick)
      else $error("divider runs while powered down");

   chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_valid && $past(addr) == `PLG_ADDR_GENERAL |-> (rd_data & ~`PLG_MASK_GENERAL) == 8'h00)
      else $error("reserved bits read nonzero");

endmodule : plg_ctrl

/* src/plg_map.svh */
`ifndef PLG_MAP_SVH
`define PLG_MAP_SVH

// Register offsets on the serial control port
`define PLG_ADDR_GENERAL 12'h0200
`define PLG_ADDR_CPUMP 12'h0201
`define PLG_ADDR_REFDIV 12'h0202
`define PLG_ADDR_UPDATE 12'h0005

// Writable bit masks; everything else reads zero
`define PLG_MASK_GENERAL 8'h17
`define PLG_MASK_CPUMP 8'h0F
`define PLG_MASK_REFDIV 8'h0F

// Field positions
`define PLG_BIT_PDOWN 0
`define PLG_BIT_CAL 1
`define PLG_BIT_SYNC 2
`define PLG_BIT_XTAL 4
`define PLG_BIT_CP_MANUAL 3
`define PLG_BIT_UPDATE 0

// Reset values
`define PLG_RST_GENERAL 8'h00
`define PLG_RST_CPUMP 8'h00
`define PLG_RST_REFDIV 8'h00

// Charge pump step and predivider zero code
`define PLG_CP_STEP_UA 11'h07D
`define PLG_REFDIV_ZERO_RATIO 5'h10

// Calibration run time, converted at the core clock rate
`define PLG_CAL_TIME_NS 1600
`define PLG_CLK_PERIOD_NS 25
`define PLG_CAL_CYCLES ((`PLG_CAL_TIME_NS + `PLG_CLK_PERIOD_NS - 1) / `PLG_CLK_PERIOD_NS)

`endif

/* src/plg_pkg.sv */
package plg_pkg;

   typedef enum logic [0:0] {
      PLG_REF_DIFF = 1'b0,
      PLG_REF_XTAL = 1'b1
   } plg_ref_mode_t;

   typedef enum logic [0:0] {
      PLG_CAL_IDLE = 1'b0,
      PLG_CAL_RUN = 1'b1
   } plg_cal_state_t;

endpackage : plg_pkg

/* src/plg_ref_prediv.sv */
module plg_ref_prediv (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Reference edges in, divided edges out
   input wire logic ref_tick,
   input wire logic [4:0] ratio,
   input wire logic power_down,
   output logic div_tick
);

   logic [4:0] count;
   logic [4:0] next_count;
   logic next_div_tick;

   always_comb begin
      next_count = count;
      next_div_tick = 1'b0;
      if (power_down) begin
         next_count = 5'h00;
      end else if (ref_tick) begin
         if (count >= ratio - 5'h01) begin
            next_count = 5'h00;
            next_div_tick = 1'b1;
         end else begin
            next_count = count + 5'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count <= 5'h00;
         div_tick <= 1'b0;
      end else begin
         count <= next_count;
         div_tick <= next_div_tick;
      end
   end

endmodule : plg_ref_prediv

/* tb/test_pll_general_and_ref_divider_ctrl.sv */
`include "plg_map.svh"

module test_pll_general_and_ref_divider_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk, rst_n, wr_en, rd_en, second_reference_pos, second_reference_neg_in;
   logic [11:0] addr;
   logic [7:0] wdata, rd_data;
   logic rd_valid, neg_out, neg_oe_n, pdown, sync_armed, sync_pulse, cal_busy, cp_manual;
   logic ref_div_tick;
   logic [10:0] cp_ua;
   logic [4:0] ratio;
   plg_pkg::plg_ref_mode_t ref_mode;
   int mismatches = 0;
   int checked = 0;
   int n_tick = 0;
   int n_sync = 0;
   int n_busy = 0;

   // Short calibration keeps the run brief
   plg_ctrl #(.CAL_CYCLES(4)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rd_data(rd_data), .rd_valid(rd_valid),
      .second_reference_pos(second_reference_pos),
      .second_reference_neg_in(second_reference_neg_in),
      .second_reference_neg_out(neg_out), .second_reference_neg_oe_n(neg_oe_n),
      .ref_mode(ref_mode), .second_loop_power_down(pdown), .sync_armed(sync_armed),
      .sync_pulse(sync_pulse), .cal_busy(cal_busy), .cp_manual(cp_manual),
      .cp_current_ua(cp_ua), .reference_predivider_ratio(ratio), .ref_div_tick(ref_div_tick)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (ref_div_tick === 1'b1) n_tick++;
      if (sync_pulse === 1'b1) n_sync++;
      if (cal_busy === 1'b1) n_busy++;
   end

   task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge core_clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask : wr

   task automatic upd();
      wr(`PLG_ADDR_UPDATE, 8'h01);
   endtask : upd

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge core_clk);
      rd_en = 1'b0;
      check("rd_valid", 11'(rd_valid), 11'h001);
      check("rd_data", 11'(rd_data), 11'(exp));
   endtask : rd

   // Reference square wave, eight core cycles a period; without pair the neg pin stays high
   task automatic ref_edges(input int n, input logic pair);
      repeat (n) begin
         @(negedge core_clk);
         second_reference_pos = 1'b1;
         second_reference_neg_in = !pair;
         repeat (4) @(negedge core_clk);
         second_reference_pos = 1'b0;
         second_reference_neg_in = 1'b1;
         repeat (3) @(negedge core_clk);
      end
      repeat (8) @(negedge core_clk);
   endtask : ref_edges

   task automatic test_regs();
      check("ratio", 11'(ratio), 11'h010);
      check("oe_n", 11'(neg_oe_n), 11'h001);
      wr(`PLG_ADDR_GENERAL, 8'hFB);
      wr(`PLG_ADDR_CPUMP, 8'hFF);
      wr(`PLG_ADDR_REFDIV, 8'hF5);
      wr(12'h203, 8'hFF);
      rd(`PLG_ADDR_GENERAL, 8'h13);
      rd(`PLG_ADDR_CPUMP, 8'h0F);
      rd(`PLG_ADDR_REFDIV, 8'h05);
      rd(12'h203, 8'h00);
      check("pdown", 11'(pdown), 11'h000);
      check("cal_busy", 11'(cal_busy), 11'h000);
      check("ratio", 11'(ratio), 11'h010);
      wr(`PLG_ADDR_GENERAL, 8'h00);
      wr(`PLG_ADDR_CPUMP, 8'h00);
   endtask : test_regs

   task automatic test_cpump();
      for (int c = 0; c < 8; c++) begin
         wr(`PLG_ADDR_CPUMP, 8'h08 | 8'(c));
         upd();
         check("cp_manual", 11'(cp_manual), 11'h001);
         check("cp_ua", cp_ua, 11'(c + 1) * 11'h07D);
      end
      wr(`PLG_ADDR_CPUMP, 8'h05);
      upd();
      check("cp_manual", 11'(cp_manual), 11'h000);
      check("cp_ua", cp_ua, 11'h000);
   endtask : test_cpump

   task automatic test_prediv();
      int t0;
      for (int c = 0; c < 16; c++) begin
         wr(`PLG_ADDR_REFDIV, 8'(c));
         upd();
         check("ratio", 11'(ratio), (c == 0) ? 11'h010 : 11'(c));
      end
      wr(`PLG_ADDR_REFDIV, 8'h03);
      upd();
      t0 = n_tick;
      ref_edges(48, 1'b1);
      check("ticks_div3", 11'(n_tick - t0), 11'h010);
      wr(`PLG_ADDR_GENERAL, 8'h01);
      upd();
      check("pdown", 11'(pdown), 11'h001);
      t0 = n_tick;
      ref_edges(4, 1'b1);
      check("ticks_off", 11'(n_tick - t0), 11'h000);
      wr(`PLG_ADDR_GENERAL, 8'h00);
      wr(`PLG_ADDR_REFDIV, 8'h00);
      upd();
      check("pdown", 11'(pdown), 11'h000);
      t0 = n_tick;
      ref_edges(48, 1'b1);
      check("ticks_div16", 11'(n_tick - t0), 11'h003);
      t0 = n_tick;
      ref_edges(32, 1'b0);
      check("ticks_neg_high", 11'(n_tick - t0), 11'h000);
   endtask : test_prediv

   task automatic test_xtal();
      wr(`PLG_ADDR_GENERAL, 8'h10);
      upd();
      check("ref_mode", 11'(ref_mode), 11'(plg_pkg::PLG_REF_XTAL));
      check("oe_n", 11'(neg_oe_n), 11'h000);
      second_reference_pos = 1'b1;
      repeat (6) @(negedge core_clk);
      check("neg_out", 11'(neg_out), 11'h000);
      second_reference_pos = 1'b0;
      repeat (6) @(negedge core_clk);
      check("neg_out", 11'(neg_out), 11'h001);
      wr(`PLG_ADDR_GENERAL, 8'h11);
      upd();
      check("oe_n", 11'(neg_oe_n), 11'h001);
      wr(`PLG_ADDR_GENERAL, 8'h00);
      upd();
      check("ref_mode", 11'(ref_mode), 11'(plg_pkg::PLG_REF_DIFF));
      check("oe_n", 11'(neg_oe_n), 11'h001);
   endtask : test_xtal

   task automatic test_sync_cal();
      int s0;
      int b0;
      s0 = n_sync;
      wr(`PLG_ADDR_GENERAL, 8'h04);
      check("sync_armed", 11'(sync_armed), 11'h000);
      upd();
      check("sync_armed", 11'(sync_armed), 11'h001);
      wr(`PLG_ADDR_GENERAL, 8'h00);
      upd();
      repeat (3) @(negedge core_clk);
      check("sync_armed", 11'(sync_armed), 11'h000);
      check("sync_count", 11'(n_sync - s0), 11'h001);
      upd();
      repeat (3) @(negedge core_clk);
      check("sync_count", 11'(n_sync - s0), 11'h001);
      // Calibration written as 0, 1, 0
      wr(`PLG_ADDR_GENERAL, 8'h00);
      upd();
      b0 = n_busy;
      wr(`PLG_ADDR_GENERAL, 8'h02);
      check("cal_busy", 11'(cal_busy), 11'h000);
      upd();
      repeat (10) @(negedge core_clk);
      check("busy_cycles", 11'(n_busy - b0), 11'h004);
      wr(`PLG_ADDR_GENERAL, 8'h00);
      upd();
   endtask : test_sync_cal

   task automatic print_verdict();
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      #(25ns * 20000);
      mismatches++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      second_reference_pos = 1'b0;
      second_reference_neg_in = 1'b0;
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      test_regs();
      test_cpump();
      test_prediv();
      test_xtal();
      test_sync_cal();
      print_verdict();
   end
endmodule : test_pll_general_and_ref_divider_ctrl
